// file: bmsd_pkg.sv
package bmsd_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int STRAP_SETTLE_NS = 100;
	localparam int STRAP_SETTLE_CYC =
		(STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROM_STAGE_NS    = 200;
	localparam int ROM_STAGE_CYC   =
		(ROM_STAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SETTLE_LAST = 4'(STRAP_SETTLE_CYC - 1);
	localparam logic [3:0] ROM_LAST    = 4'(ROM_STAGE_CYC - 1);

	// Strap pin positions on the multiplexed I/O bus
	localparam int MIO_LO       = 2;
	localparam int MIO_HI       = 8;
	localparam int MIO_JTAG     = 2;
	localparam int MIO_NOR_BIT  = 3;
	localparam int MIO_SRC_LO   = 4;
	localparam int MIO_SRC_HI   = 5;
	localparam int MIO_PLL      = 6;
	localparam int MIO_VMODE0   = 7;
	localparam int MIO_VMODE1   = 8;

	// Source pin pairs {io5, io4}
	localparam logic [1:0] PAIR_JTAG = 2'h0;
	localparam logic [1:0] PAIR_QSPI = 2'h2;
	localparam logic [1:0] PAIR_SD   = 2'h3;

	// APB register byte offsets
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CTRL   = 12'h004;
	localparam logic [11:0] REG_STAGE  = 12'h008;
	localparam logic [11:0] REG_FLAGS  = 12'h00C;

	// Field positions
	localparam int CTRL_RECONFIG = 0;
	localparam int FLAG_PROG     = 0;
	localparam int FLAG_AUTH     = 1;
	localparam int STAT_STRAP_LO = 0;
	localparam int STAT_MODE_LO  = 8;
	localparam int STAT_FN_BIT   = 16;
	localparam int STAGE_ST_LO   = 0;
	localparam int STAGE_SECURE  = 8;
	localparam int STAGE_DONE    = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		SRC_JTAG = 3'h0,
		SRC_QSPI = 3'h1,
		SRC_SD   = 3'h2,
		SRC_BAD  = 3'h7
	} bmsd_src_t;

	typedef struct packed {
		logic      valid;
		logic      bank501_1v8;
		logic      bank500_1v8;
		logic      pll_bypass;
		logic      jtag_indep;
		bmsd_src_t src;
	} bmsd_mode_t;

	typedef enum logic [5:0] {
		ST_SAMPLE  = 6'h01,
		ST_ROM     = 6'h02,
		ST_FSBL    = 6'h04,
		ST_LOAD_PL = 6'h08,
		ST_RUN     = 6'h10,
		ST_FAIL    = 6'h20
	} bmsd_state_t;

endpackage

// file: bmsd_strap_capture.sv
`timescale 1ns/1ps
module bmsd_strap_capture
	import bmsd_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [MIO_HI:MIO_LO]   multiplexed_io_in,
	output logic      [MIO_HI:MIO_LO]   strap,
	output logic                        captured
);

	logic [3:0] settle;

	// Count settle cycles after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			settle <= 4'h0;
		else if (!captured && settle != SETTLE_LAST)
			settle <= settle + 4'h1;
	end

	// One capture, then held until next reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap    <= '0;
			captured <= 1'b0;
		end
		else if (!captured && settle == SETTLE_LAST)
		begin
			strap    <= multiplexed_io_in;
			captured <= 1'b1;
		end
	end

endmodule

// file: bmsd_mode_decode.sv
`timescale 1ns/1ps
module bmsd_mode_decode
	import bmsd_pkg::*;
(
	input  wire logic [MIO_HI:MIO_LO] strap,
	input  wire logic                 captured,
	output bmsd_mode_t                mode
);

	logic [1:0] pair;

	always_comb
	begin
		pair = {strap[MIO_SRC_HI], strap[MIO_SRC_LO]};
		mode.valid       = captured;
		mode.jtag_indep  = strap[MIO_JTAG];
		mode.pll_bypass  = strap[MIO_PLL];
		mode.bank500_1v8 = strap[MIO_VMODE0];
		mode.bank501_1v8 = strap[MIO_VMODE1];
		// NOR select bit set means an unsupported source
		if (strap[MIO_NOR_BIT])
			mode.src = SRC_BAD;
		else if (pair == PAIR_QSPI)
			mode.src = SRC_QSPI;
		else if (pair == PAIR_SD)
			mode.src = SRC_SD;
		else if (pair == PAIR_JTAG)
			mode.src = SRC_JTAG;
		else
			mode.src = SRC_BAD;
	end

endmodule

// file: bmsd_boot_ctrl.sv
// Overview of operation
// - At reset release, sample mode straps and pick the primary boot source.
// - Straps share I/O 2..8; sampling ends before pins go functional.
// - Multi-stage boot, secure or not; this block masters the whole boot.
// - I/O 2 low gives cascade JTAG, high gives independent JTAG.
// - Boot mode bits 2..0 come from I/O 5 down to 3.
// - I/O5 high, I/O4 low is QSPI; both high SD; both low JTAG.
// - I/O 6 controls PLL use; board ties it low, PLL enabled.
// - I/O 8..7 set bank voltage: bit0 low 3.3V, bit1 high 1.8V.
// - Logic loaded by this block; program pulse never reconfigures it.
// - Init pin never holds boot; reset and the wait for pl_cfg_done delay it, only power-on reset restarts it.
// - Low pull-up control enables I/O pull-ups during configuration.
`timescale 1ns/1ps
module bmsd_boot_ctrl
	import bmsd_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [31:0]          paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [MIO_HI:MIO_LO] multiplexed_io_in,
	input  wire logic                 image_secure,
	input  wire logic                 auth_pass,
	input  wire logic                 program_req_n,
	input  wire logic                 config_pullup_control_n,
	input  wire logic                 pl_cfg_done,
	output logic                      mio_function_en,
	output bmsd_mode_t                boot_mode,
	output logic                      pl_cfg_start,
	output logic                      pl_configured,
	output logic                      config_pullup_en,
	output logic                      secure_boot,
	output logic                      boot_failed
);

	logic [MIO_HI:MIO_LO] strap;
	logic                 captured;
	bmsd_mode_t           decoded;
	bmsd_state_t          state;
	bmsd_state_t          next_state;
	logic [3:0]           rom_cnt;
	logic                 prog_d;
	logic                 prog_seen;
	logic                 auth_fail;
	logic                 reconfig_req;
	logic                 wr_en;
	logic                 rd_en;
	logic                 addr_ok;
	logic                 wr_ctrl;
	logic                 wr_flags;
	logic [31:0]          next_prdata;

	// Word match for register decode
	function automatic logic hit(input logic [31:0] a,
		input logic [11:0] off);
		hit = (a[31:12] == 20'h0_0000) && (a[11:0] == off);
	endfunction

	bmsd_strap_capture u_capture
	(
		.pclk              (pclk),
		.presetn           (presetn),
		.multiplexed_io_in (multiplexed_io_in),
		.strap             (strap),
		.captured          (captured)
	);

	bmsd_mode_decode u_decode
	(
		.strap    (strap),
		.captured (captured),
		.mode     (decoded)
	);

	// APB handshake: zero wait states
	assign pready  = 1'b1;
	assign addr_ok = hit(paddr, REG_STATUS) || hit(paddr, REG_CTRL)
		|| hit(paddr, REG_STAGE) || hit(paddr, REG_FLAGS);
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en   = psel && penable && pwrite && addr_ok;
	assign rd_en   = psel && !penable && !pwrite;
	assign wr_ctrl  = wr_en && hit(paddr, REG_CTRL);
	assign wr_flags = wr_en && hit(paddr, REG_FLAGS);

	// Pins go to their normal function only after capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mio_function_en <= 1'b0;
		else
			mio_function_en <= captured;
	end

	// Decoded mode registered and frozen after capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			boot_mode <= '0;
		else if (captured && !boot_mode.valid)
			boot_mode <= decoded;
	end

	// Software reconfiguration request, pending until taken in run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reconfig_req <= CTRL_RESET[CTRL_RECONFIG];
		else if (wr_ctrl && pwdata[CTRL_RECONFIG])
			reconfig_req <= 1'b1;
		else if (state == ST_RUN)
			reconfig_req <= 1'b0;
	end

	// Program request edges are only recorded
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prog_d <= 1'b1;
		else
			prog_d <= program_req_n;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prog_seen <= 1'b0;
		else if (prog_d && !program_req_n)
			prog_seen <= 1'b1;
		else if (wr_flags && pwdata[FLAG_PROG])
			prog_seen <= 1'b0;
	end

	// Secure image check result
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			secure_boot <= 1'b0;
		else if (state == ST_ROM && rom_cnt == ROM_LAST)
			secure_boot <= image_secure;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			auth_fail <= 1'b0;
		else if (state == ST_FSBL && secure_boot && !auth_pass)
			auth_fail <= 1'b1;
		else if (wr_flags && pwdata[FLAG_AUTH])
			auth_fail <= 1'b0;
	end

	// Boot ROM stage timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rom_cnt <= 4'h0;
		else if (state != ST_ROM)
			rom_cnt <= 4'h0;
		else if (rom_cnt != ROM_LAST)
			rom_cnt <= rom_cnt + 4'h1;
	end

	// Boot sequencer: no wait on any init pin; held by reset, strap capture, the ROM timer and pl_cfg_done
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_SAMPLE:
			begin
				if (boot_mode.valid)
					next_state = ST_ROM;
			end
			ST_ROM:
			begin
				if (rom_cnt == ROM_LAST)
				begin
					if (boot_mode.src == SRC_BAD)
						next_state = ST_FAIL;
					else
						next_state = ST_FSBL;
				end
			end
			ST_FSBL:
			begin
				if (secure_boot && !auth_pass)
					next_state = ST_FAIL;
				else
					next_state = ST_LOAD_PL;
			end
			ST_LOAD_PL:
			begin
				if (pl_cfg_done)
					next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (reconfig_req)
					next_state = ST_LOAD_PL;
			end
			ST_FAIL:
			begin
				next_state = ST_FAIL;
			end
			default:
			begin
				next_state = ST_FAIL;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_SAMPLE;
		else
			state <= next_state;
	end

	// Start pulse on each entry to logic configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pl_cfg_start <= 1'b0;
		else
			pl_cfg_start <= (next_state == ST_LOAD_PL)
				&& (state != ST_LOAD_PL);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pl_configured <= 1'b0;
		else if (next_state == ST_LOAD_PL)
			pl_configured <= 1'b0;
		else if (state == ST_LOAD_PL && pl_cfg_done)
			pl_configured <= 1'b1;
	end

	// Pull-ups only while configuring and control held low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			config_pullup_en <= 1'b0;
		else
			config_pullup_en <= (next_state == ST_LOAD_PL)
				&& !config_pullup_control_n;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			boot_failed <= 1'b0;
		else
			boot_failed <= (next_state == ST_FAIL);
	end

	// Read data mux
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (hit(paddr, REG_STATUS))
		begin
			next_prdata[STAT_STRAP_LO +: $bits(strap)] = strap;
			next_prdata[STAT_MODE_LO +: $bits(bmsd_mode_t)]
				= boot_mode;
			next_prdata[STAT_FN_BIT] = mio_function_en;
		end
		else if (hit(paddr, REG_CTRL))
			next_prdata[CTRL_RECONFIG] = reconfig_req;
		else if (hit(paddr, REG_STAGE))
		begin
			next_prdata[STAGE_ST_LO +: $bits(state)] = state;
			next_prdata[STAGE_SECURE] = secure_boot;
			next_prdata[STAGE_DONE]   = pl_configured;
		end
		else if (hit(paddr, REG_FLAGS))
		begin
			next_prdata[FLAG_PROG] = prog_seen;
			next_prdata[FLAG_AUTH] = auth_fail;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
			prdata <= next_prdata;
	end

endmodule

// file: bmsd_boot_ctrl_sva.sv
`timescale 1ns/1ps
module bmsd_boot_ctrl_sva
	import bmsd_pkg::*;
(
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic [31:0]          paddr,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pslverr,
	input wire logic [MIO_HI:MIO_LO] multiplexed_io_in,
	input wire logic                 program_req_n,
	input wire logic                 config_pullup_control_n,
	input wire logic                 mio_function_en,
	input wire bmsd_mode_t           boot_mode,
	input wire logic                 pl_cfg_start,
	input wire logic                 pl_configured,
	input wire logic                 config_pullup_en,
	input wire logic                 boot_failed
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	function automatic bmsd_src_t src_of(logic [MIO_HI:MIO_LO] m);
		if (m[MIO_NOR_BIT])
			return SRC_BAD;
		case (m[MIO_SRC_HI:MIO_SRC_LO])
			PAIR_JTAG: return SRC_JTAG;
			PAIR_QSPI: return SRC_QSPI;
			PAIR_SD:   return SRC_SD;
			default:   return SRC_BAD;
		endcase
	endfunction
	sequence s_rise;
		$rose(boot_mode.valid);
	endsequence
	sequence s_pulse;
		pl_cfg_start ##1 !pl_cfg_start;
	endsequence
	property p_src;
		s_rise |-> boot_mode.src == src_of($past(multiplexed_io_in));
	endproperty
	a_src: assert property (p_src) else $error("boot source bad");
	property p_jtag;
		s_rise |-> boot_mode.jtag_indep == $past(multiplexed_io_in[2]);
	endproperty
	a_jtag: assert property (p_jtag) else $error("jtag mode bad");
	property p_pll;
		s_rise |-> boot_mode.pll_bypass == $past(multiplexed_io_in[6]);
	endproperty
	a_pll: assert property (p_pll) else $error("pll mode bad");
	property p_vmode;
		s_rise |-> {boot_mode.bank501_1v8, boot_mode.bank500_1v8}
			== $past(multiplexed_io_in[8:7]);
	endproperty
	a_vmode: assert property (p_vmode) else $error("bank mode bad");
	property p_hold;
		boot_mode.valid |=> $stable(boot_mode);
	endproperty
	a_hold: assert property (p_hold) else $error("mode changed");
	property p_fn;
		mio_function_en |-> boot_mode.valid;
	endproperty
	a_fn: assert property (p_fn) else $error("pins freed early");
	property p_start;
		pl_cfg_start |-> mio_function_en ##0 s_pulse;
	endproperty
	a_start: assert property (p_start) else $error("start pulse bad");
	property p_prog;
		pl_configured && $fell(program_req_n) |=> !pl_cfg_start [*3];
	endproperty
	a_prog: assert property (p_prog) else $error("program restarted");
	property p_pullup;
		config_pullup_en |-> !$past(config_pullup_control_n);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pullup bad");
	property p_fail;
		boot_mode.valid && boot_mode.src == SRC_BAD |-> ##[0:11] boot_failed;
	endproperty
	a_fail: assert property (p_fail) else $error("bad mode ran");
	property p_slverr;
		psel && penable && paddr[11:0] == 12'h010 |-> pslverr;
	endproperty
	a_slverr: assert property (p_slverr) else $error("no slverr");
endmodule

bind bmsd_boot_ctrl bmsd_boot_ctrl_sva u_sva (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pslverr(pslverr), .multiplexed_io_in(multiplexed_io_in),
	.program_req_n(program_req_n),
	.config_pullup_control_n(config_pullup_control_n),
	.mio_function_en(mio_function_en), .boot_mode(boot_mode),
	.pl_cfg_start(pl_cfg_start), .pl_configured(pl_configured),
	.config_pullup_en(config_pullup_en), .boot_failed(boot_failed));

// file: bmsd_strap_board.sv
`timescale 1ns/1ps
module bmsd_strap_board
	import bmsd_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 jtag_sel,
	input  wire logic [1:0]           src_sel,
	input  wire logic                 fn_en,
	output logic      [MIO_HI:MIO_LO] multiplexed_io
);
	logic [MIO_HI:MIO_LO] busy;
	initial busy = 7'h2A;
	// Pins carry changing traffic once in general use
	always @(posedge pclk)
		busy <= ~busy;
	always_comb
		if (fn_en)
			multiplexed_io = busy;
		else
			multiplexed_io = {1'h1, 2'h0, src_sel, 1'h0, jtag_sel};
endmodule

// file: tb_bmsd_boot_ctrl.sv
`timescale 1ns/1ps
module tb_bmsd_boot_ctrl
	import bmsd_pkg::*;
;
	logic                 pclk, presetn, psel, penable, pwrite, pready;
	logic [31:0]          paddr, pwdata, prdata, rd;
	logic                 pslverr, image_secure, auth_pass, program_req_n;
	logic                 config_pullup_control_n, pl_cfg_done, err;
	logic                 mio_function_en, pl_cfg_start, pl_configured;
	logic                 config_pullup_en, secure_boot, boot_failed;
	logic                 jtag_sel;
	logic [1:0]           src_sel;
	logic [MIO_HI:MIO_LO] multiplexed_io_in;
	bmsd_mode_t           boot_mode;
	int                   n_mismatch, checked;

	initial pclk = 1'h0;
	always #10 pclk = ~pclk;

	bmsd_strap_board u_bmsd_strap_board (.pclk(pclk), .jtag_sel(jtag_sel),
		.src_sel(src_sel), .fn_en(mio_function_en), .multiplexed_io(multiplexed_io_in));
	bmsd_boot_ctrl u_bmsd_boot_ctrl (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .multiplexed_io_in(multiplexed_io_in),
		.image_secure(image_secure), .auth_pass(auth_pass),
		.program_req_n(program_req_n),
		.config_pullup_control_n(config_pullup_control_n),
		.pl_cfg_done(pl_cfg_done), .mio_function_en(mio_function_en),
		.boot_mode(boot_mode), .pl_cfg_start(pl_cfg_start),
		.pl_configured(pl_configured), .config_pullup_en(config_pullup_en),
		.secure_boot(secure_boot), .boot_failed(boot_failed));

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {20'h00000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic boot(input logic j, input logic [1:0] s);
		presetn <= 1'h0;
		jtag_sel <= j;
		src_sel <= s;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 20 && mio_function_en !== 1'h1; i++)
			@(negedge pclk);
		@(posedge pclk);
	endtask

	task automatic t_modes;
		logic [1:0] pr [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
		bmsd_src_t sx [4] = '{SRC_QSPI, SRC_SD, SRC_JTAG, SRC_BAD};
		logic [7:0] m;
		for (int k = 0; k < 4; k++)
		begin
			boot(k == 2, pr[k]);
			m = {4'hC, k == 2, sx[k]};
			chk("mode", {24'h0, m}, {24'h0, boot_mode});
			apb(1'h0, REG_STATUS, 32'h0);
			chk("status", {15'h0, 1'h1, m, 4'h4, pr[k], 1'h0, m[3]}, rd);
			repeat (20) @(posedge pclk);
			chk("held", {24'h0, m}, {24'h0, boot_mode});
			chk("failed", {31'h0, k == 3}, {31'h0, boot_failed});
			chk("pullup off", 32'h0, {31'h0, config_pullup_en});
		end
		$display("test modes done");
	endtask

	task automatic t_boot;
		image_secure <= 1'h1;
		auth_pass <= 1'h1;
		config_pullup_control_n <= 1'h0;
		boot(1'h0, 2'h2);
		for (int i = 0; i < 40 && pl_cfg_start !== 1'h1; i++)
			@(negedge pclk);
		chk("start", 32'h1, {31'h0, pl_cfg_start});
		@(negedge pclk);
		chk("pullup", 32'h1, {31'h0, config_pullup_en});
		@(posedge pclk);
		pl_cfg_done <= 1'h1;
		for (int i = 0; i < 10 && pl_configured !== 1'h1; i++)
			@(negedge pclk);
		apb(1'h0, REG_STAGE, 32'h0);
		chk("stage", 32'h0000_0310, rd);
		program_req_n <= 1'h0;
		repeat (2) @(posedge pclk);
		program_req_n <= 1'h1;
		repeat (4) @(posedge pclk);
		chk("configured", 32'h1, {31'h0, pl_configured});
		apb(1'h0, REG_FLAGS, 32'h0);
		chk("flags", 32'h1, rd);
		apb(1'h1, REG_FLAGS, 32'h1);
		apb(1'h0, REG_FLAGS, 32'h0);
		chk("flags clear", 32'h0, rd);
		apb(1'h1, REG_CTRL, 32'h1);
		for (int i = 0; i < 10 && pl_cfg_start !== 1'h1; i++)
			@(negedge pclk);
		chk("reconfig", 32'h1, {31'h0, pl_cfg_start});
		@(posedge pclk);
		apb(1'h0, 12'h010, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		$display("test boot done");
	endtask

	task automatic t_auth;
		image_secure <= 1'h1;
		auth_pass <= 1'h0;
		boot(1'h0, 2'h3);
		for (int i = 0; i < 30 && boot_failed !== 1'h1; i++)
			@(negedge pclk);
		chk("auth failed", 32'h1, {31'h0, boot_failed});
		chk("auth start", 32'h0, {31'h0, pl_cfg_start});
		apb(1'h0, REG_STAGE, 32'h0);
		chk("auth stage", 32'h0000_0120, rd);
		apb(1'h0, REG_FLAGS, 32'h0);
		chk("auth flag", 32'h2, rd);
		apb(1'h1, REG_FLAGS, 32'h2);
		apb(1'h0, REG_FLAGS, 32'h0);
		chk("auth clear", 32'h0, rd);
		apb(1'h1, REG_CTRL, 32'h1);
		apb(1'h0, REG_CTRL, 32'h0);
		chk("ctrl pending", 32'h1, rd);
		chk("no reload", 32'h0, {31'h0, pl_configured});
		$display("test auth done");
	endtask

	task automatic final_report;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		final_report;
	end

	initial
	begin
		presetn = 1'h0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{image_secure, auth_pass, pl_cfg_done} = '0;
		{program_req_n, config_pullup_control_n} = 2'h3;
		jtag_sel = 1'h0;
		src_sel = 2'h2;
		t_modes;
		t_boot;
		t_auth;
		final_report;
	end
endmodule
